// [inc/fp_regs_cfg.svh]
// register encodings, field positions and reset values of the fp register bank
`ifndef FP_REGS_CFG_SVH
`define FP_REGS_CFG_SVH

`define FP_ENC_OP0_SYS        2'h3
`define FP_ENC_OP1_USER       3'h3
`define FP_ENC_OP1_ID         3'h0
`define FP_ENC_CRN_FP         4'h4
`define FP_ENC_CRM_FP         4'h4
`define FP_ENC_CRN_ID         4'h0
`define FP_ENC_CRM_ID         4'h3
`define FP_ENC_OP2_CTRL       3'h0
`define FP_ENC_OP2_STAT       3'h1
`define FP_ENC_OP2_FEAT0      3'h0

`define FP_CTRL_AHP_BIT       26
`define FP_CTRL_DN_BIT        25
`define FP_CTRL_FZ_BIT        24
`define FP_CTRL_RM_HI         23
`define FP_CTRL_RM_LO         22
`define FP_CTRL_WMASK         32'h07C00000
`define FP_CTRL_RESET         32'h00000000

`define FP_STAT_FLAG_HI       31
`define FP_STAT_FLAG_LO       28
`define FP_STAT_QC_BIT        27
`define FP_STAT_IDC_BIT       7
`define FP_STAT_EXC_HI        4
`define FP_STAT_EXC_LO        0
`define FP_STAT_WMASK         32'hF800009F
`define FP_STAT_RESET         32'h00000000

`define FP_FEAT0_VALUE        32'h10110222

`endif

// [inc/fp_regs_pkg.sv]
// types shared by the fp register bank modules
`default_nettype none
package fp_regs_pkg;
  typedef enum logic [1:0] {
    RND_NEAREST,
    RND_PLUS_INF,
    RND_MINUS_INF,
    RND_ZERO
  } rounding_select_t;

  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_CONTROL,
    SEL_STATUS,
    SEL_FEATURE0
  } reg_sel_t;

  typedef enum {
    ST_IDLE,
    ST_ANSWER
  } access_state_t;
endpackage
`default_nettype wire

// [verification/core_sysreg_mover.sv]
// core-side model issuing system-register moves to the fp register bank
`default_nettype none
module core_sysreg_mover (
  input  wire logic        ref_clk,
  input  wire logic        resp_valid,
  input  wire logic        resp_undef,
  input  wire logic [31:0] resp_rdata,
  output logic             acc_valid,
  output logic             acc_write,
  output logic [1:0]       acc_op0,
  output logic [2:0]       acc_op1,
  output logic [3:0]       acc_crn,
  output logic [3:0]       acc_crm,
  output logic [2:0]       acc_op2,
  output logic [1:0]       acc_el,
  output logic             acc_secure,
  output logic [31:0]      acc_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle cycles before each request, to play a slow core
  int gap = 0;
  initial begin
    {acc_valid, acc_write, acc_op0, acc_op1, acc_crn, acc_crm} = '0;
    {acc_op2, acc_el, acc_secure, acc_wdata} = '0;
  end
  // which: 0 control, 1 status, 2 feature 0, 3 an unmapped neighbour
  task automatic access(input logic [1:0] which, input logic wr,
                        input logic [1:0] el, input logic sec,
                        input logic [31:0] wd, output logic ok,
                        output logic und, output logic [31:0] rd);
    logic [13:0] enc;
    case (which)
      2'h0: enc = 14'b011_0100_0100_000;
      2'h1: enc = 14'b011_0100_0100_001;
      2'h2: enc = 14'b000_0000_0011_000;
      default: enc = 14'b011_0100_0100_111;
    endcase
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    acc_valid <= 1'b1;
    acc_write <= wr;
    acc_op0 <= 2'h3;
    {acc_op1, acc_crn, acc_crm, acc_op2} <= enc;
    acc_el <= el;
    acc_secure <= sec;
    acc_wdata <= wd;
    @(posedge ref_clk);
    acc_valid <= 1'b0;
    // released data must not look like a still-valid value
    acc_wdata <= ~wd;
    #1;
    ok = resp_valid;
    und = resp_undef;
    rd = resp_rdata;
  endtask
endmodule // core_sysreg_mover
`default_nettype wire

// [verification/fp_control_status_regs_test.sv]
// self-checking bench for the fp control, status and feature registers
`default_nettype none
module fp_control_status_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  import fp_regs_pkg::*;
  logic ref_clk, resetn, cmp_flags_valid, sec;
  logic [3:0] cmp_flags;
  logic sat_event, idc_event, ixc_event, ufc_event;
  logic ofc_event, dzc_event, ioc_event;
  logic acc_valid, acc_write, acc_secure, resp_valid, resp_undef;
  logic [1:0] acc_op0, acc_el;
  logic [2:0] acc_op1, acc_op2;
  logic [3:0] acc_crn, acc_crm;
  logic [31:0] acc_wdata, resp_rdata, exp;
  logic alt_half_precision, default_nan_enable, flush_zero_enable;
  rounding_select_t rounding_select;
  int num_errors = 0;
  int num_checks = 0;
  int pos[7] = '{0, 1, 2, 3, 4, 7, 27};

  fp_control_status_regs DUT (.ref_clk, .resetn, .acc_valid, .acc_write,
    .acc_op0, .acc_op1, .acc_crn, .acc_crm, .acc_op2, .acc_el, .acc_secure,
    .acc_wdata, .cmp_flags_valid, .cmp_flags, .sat_event, .idc_event,
    .ixc_event, .ufc_event, .ofc_event, .dzc_event, .ioc_event, .resp_valid,
    .resp_undef, .resp_rdata, .alt_half_precision, .default_nan_enable,
    .flush_zero_enable, .rounding_select);
  core_sysreg_mover core (.ref_clk, .resp_valid, .resp_undef, .resp_rdata,
    .acc_valid, .acc_write, .acc_op0, .acc_op1, .acc_crn, .acc_crm,
    .acc_op2, .acc_el, .acc_secure, .acc_wdata);

  function automatic logic [31:0] modes();
    return {27'h0, alt_half_precision, default_nan_enable,
            flush_zero_enable, rounding_select};
  endfunction
  task automatic chk_word(input string what, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_flag(input string what, input logic e, g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic wr_reg(input logic [1:0] w, el, input logic [31:0] d,
                        input logic eu);
    logic ok, u;
    logic [31:0] r;
    core.access(w, 1'b1, el, sec, d, ok, u, r);
    chk_flag("write answer", 1'b1, ok);
    chk_flag("write undef", eu, u);
    chk_word("write rdata", 32'h0, r);
  endtask
  task automatic rd_chk(input string what, input logic [1:0] w, el,
                        input logic [31:0] e, input logic eu);
    logic ok, u;
    logic [31:0] r;
    core.access(w, 1'b0, el, sec, 32'h0, ok, u, r);
    chk_flag("read answer", 1'b1, ok);
    chk_flag("read undef", eu, u);
    chk_word(what, e, r);
  endtask
  task automatic pulse(input logic [6:0] e, input logic cv,
                       input logic [3:0] cf);
    @(posedge ref_clk);
    {sat_event, idc_event, ixc_event, ufc_event} <= e[6:3];
    {ofc_event, dzc_event, ioc_event} <= e[2:0];
    cmp_flags_valid <= cv;
    cmp_flags <= cf;
    @(posedge ref_clk);
    {sat_event, idc_event, ixc_event, ufc_event} <= '0;
    {ofc_event, dzc_event, ioc_event} <= '0;
    cmp_flags_valid <= 1'b0;
    cmp_flags <= ~cf;
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    end_sim();
  end
  initial begin
    resetn = 1'b0;
    sec = 1'b0;
    cmp_flags_valid = 1'b0;
    cmp_flags = 4'h0;
    {sat_event, idc_event, ixc_event, ufc_event} = '0;
    {ofc_event, dzc_event, ioc_event} = '0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    rd_chk("control", 2'h0, 2'h1, 32'h0, 1'b0);
    rd_chk("status", 2'h1, 2'h1, 32'h0, 1'b0);
    chk_word("modes", 32'h0, modes());
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      exp = (32'h1 << (24 + i)) | (32'(i) << 22);
      wr_reg(2'h0, 2'h1, exp, 1'b0);
      rd_chk("control", 2'h0, 2'h1, exp & 32'h07C00000, 1'b0);
      exp = {27'h0, i == 2, i == 1, i == 0, 2'(i)};
      chk_word("modes", exp, modes());
    end
    wr_reg(2'h0, 2'h1, 32'hFFFFFFFF, 1'b0);
    rd_chk("control", 2'h0, 2'h1, 32'h07C00000, 1'b0);
    chk_word("modes", 32'h0000001F, modes());
    $display("test control done");
    core.gap = 2;
    for (int k = 0; k < 8; k++) begin
      sec = k[0];
      exp = 32'(k);
      wr_reg(2'h0, 2'(k >> 1), exp << 22, 1'b0);
      rd_chk("control", 2'h0, 2'(k >> 1), exp << 22, 1'b0);
      wr_reg(2'h1, 2'(k >> 1), exp, 1'b0);
      rd_chk("status", 2'h1, 2'(k >> 1), exp, 1'b0);
    end
    core.gap = 0;
    sec = 1'b0;
    $display("test levels done");
    wr_reg(2'h1, 2'h1, 32'hFFFFFFFF, 1'b0);
    rd_chk("status", 2'h1, 2'h1, 32'hF800009F, 1'b0);
    wr_reg(2'h1, 2'h0, 32'h0, 1'b0);
    rd_chk("status", 2'h1, 2'h0, 32'h0, 1'b0);
    exp = 32'h0;
    for (int k = 0; k < 7; k++) begin
      pulse(7'h1 << k, 1'b0, 4'h0);
      exp = exp | (32'h1 << pos[k]);
      rd_chk("status", 2'h1, 2'h1, exp, 1'b0);
    end
    pulse(7'h7F, 1'b1, 4'hA);
    rd_chk("status", 2'h1, 2'h1, exp | 32'hA0000000, 1'b0);
    pulse(7'h00, 1'b1, 4'h5);
    rd_chk("status", 2'h1, 2'h1, exp | 32'h50000000, 1'b0);
    wr_reg(2'h1, 2'h2, 32'h0, 1'b0);
    rd_chk("status", 2'h1, 2'h2, 32'h0, 1'b0);
    $display("test status done");
    exp = 32'h10110222;
    for (int el = 1; el < 4; el++)
      rd_chk("feature", 2'h2, 2'(el), exp, 1'b0);
    rd_chk("feature el0", 2'h2, 2'h0, 32'h0, 1'b1);
    wr_reg(2'h2, 2'h1, 32'hFFFFFFFF, 1'b1);
    rd_chk("feature", 2'h2, 2'h3, 32'h10110222, 1'b0);
    wr_reg(2'h3, 2'h1, 32'hFFFFFFFF, 1'b1);
    rd_chk("unmapped", 2'h3, 2'h1, 32'h0, 1'b1);
    rd_chk("control", 2'h0, 2'h1, 32'h01C00000, 1'b0);
    $display("test feature done");
    end_sim();
  end
endmodule // fp_control_status_regs_test
`default_nettype wire

// [verilog/fp_control_status_regs.sv]
// fp control, status and feature id system registers of the core
// Operation
// - control bit 26 picks ieee (0) or alternative (1) half precision
// - control bit 25 set makes nan operations return the default nan
// - control bit 24 set enables flush-to-zero, clear is full ieee
// - control bits 23:22 pick nearest, plus inf, minus inf, zero rounding
// - control and status are read/write at every exception level
// - control is reached at encoding 11 011 0100 0100 000
// - status is reached at encoding 11 011 0100 0100 001
// - status bits 31:28 hold comparison flags of the 32-bit state
// - saturation sticky bit 27 sets on saturation until written zero
// - input denormal sticky bit 7 sets on event until written zero
// - inexact sticky bit 4 sets on event until written zero
// - underflow sticky bit 3 sets on event until written zero
// - overflow sticky bit 2 sets on event until written zero
// - divide by zero sticky bit 1 sets on event until written zero
// - invalid operation sticky bit 0 sets on event until written zero
// - feature register 0 is read-only, not reachable from EL0
// - feature 0 reports rounding 1, short vector 0, sqrt 1, divide 1
// - feature 0 reports trapping 0 and double precision 2
// - feature 0 bits 3:0 read 2, thirty-two 64-bit registers
// - feature 0 is read at encoding 11 000 0000 0011 000
// - feature 0 holds fixed value 0x10110222
// - control and status reset to zero
`default_nettype none
`include "fp_regs_cfg.svh"
module fp_control_status_regs
  import fp_regs_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       acc_valid,
  input  wire logic       acc_write,
  input  wire logic [1:0] acc_op0,
  input  wire logic [2:0] acc_op1,
  input  wire logic [3:0] acc_crn,
  input  wire logic [3:0] acc_crm,
  input  wire logic [2:0] acc_op2,
  input  wire logic [1:0] acc_el,
  input  wire logic       acc_secure,
  input  wire logic [31:0] acc_wdata,
  input  wire logic       cmp_flags_valid,
  input  wire logic [3:0] cmp_flags,
  input  wire logic       sat_event,
  input  wire logic       idc_event,
  input  wire logic       ixc_event,
  input  wire logic       ufc_event,
  input  wire logic       ofc_event,
  input  wire logic       dzc_event,
  input  wire logic       ioc_event,
  output logic            resp_valid,
  output logic            resp_undef,
  output logic [31:0]     resp_rdata,
  output logic            alt_half_precision,
  output logic            default_nan_enable,
  output logic            flush_zero_enable,
  output rounding_select_t rounding_select
);
  localparam int STICKY_N = 7;

  // fixed feature value, taken whole as one constant from the configuration header
  localparam logic [31:0] FEATURE0 = `FP_FEAT0_VALUE;

  logic            hit;
  reg_sel_t        sel;
  logic            wr_ctrl;
  logic            wr_stat;
  logic [31:0]     ctrl_r;
  logic [3:0]      cmp_r;
  logic [STICKY_N-1:0] sticky_r;
  logic [STICKY_N-1:0] sticky_hw;
  logic [STICKY_N-1:0] sticky_wv;
  logic [31:0]     stat_view;
  logic [31:0]     rdata_nxt;
  access_state_t   state_r;

  // secure state does not change access to this bank
  logic unused_secure;
  assign unused_secure = acc_secure;

  fp_sysreg_decode u_decode (
    .op0       (acc_op0),
    .op1       (acc_op1),
    .crn       (acc_crn),
    .crm       (acc_crm),
    .op2       (acc_op2),
    .exc_level (acc_el),
    .is_write  (acc_write),
    .hit       (hit),
    .sel       (sel)
  );

  assign wr_ctrl = acc_valid && acc_write && sel == SEL_CONTROL;
  assign wr_stat = acc_valid && acc_write && sel == SEL_STATUS;

  // control: only the mode bits are writable
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= `FP_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= acc_wdata & `FP_CTRL_WMASK;
    end
  end

  // mode outputs are copies of the register so they come from flops
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      alt_half_precision <= 1'b0;
      default_nan_enable <= 1'b0;
      flush_zero_enable  <= 1'b0;
      rounding_select    <= RND_NEAREST;
    end else if (wr_ctrl) begin
      alt_half_precision <= acc_wdata[`FP_CTRL_AHP_BIT];
      default_nan_enable <= acc_wdata[`FP_CTRL_DN_BIT];
      flush_zero_enable  <= acc_wdata[`FP_CTRL_FZ_BIT];
      rounding_select    <= rounding_select_t'(
        acc_wdata[`FP_CTRL_RM_HI:`FP_CTRL_RM_LO]);
    end
  end

  // comparison flags: a new comparison result wins over a software write
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cmp_r <= 4'h0;
    end else if (cmp_flags_valid) begin
      cmp_r <= cmp_flags;
    end else if (wr_stat) begin
      cmp_r <= acc_wdata[`FP_STAT_FLAG_HI:`FP_STAT_FLAG_LO];
    end
  end

  // sticky order: [6]=saturation [5]=input denormal [4:0]=ixc..ioc
  assign sticky_hw = {sat_event, idc_event, ixc_event, ufc_event,
                      ofc_event, dzc_event, ioc_event};
  assign sticky_wv = {acc_wdata[`FP_STAT_QC_BIT], acc_wdata[`FP_STAT_IDC_BIT],
                      acc_wdata[`FP_STAT_EXC_HI:`FP_STAT_EXC_LO]};

  genvar gi;
  generate
    for (gi = 0; gi < STICKY_N; gi++) begin : g_sticky
      fp_sticky_bit u_sticky (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .hw_set   (sticky_hw[gi]),
        .sw_write (wr_stat),
        .sw_value (sticky_wv[gi]),
        .flag_r   (sticky_r[gi])
      );
    end
  endgenerate

  // reserved status bits read as zero
  always_comb begin
    stat_view = 32'h00000000;
    stat_view[`FP_STAT_FLAG_HI:`FP_STAT_FLAG_LO] = cmp_r;
    stat_view[`FP_STAT_QC_BIT] = sticky_r[6];
    stat_view[`FP_STAT_IDC_BIT] = sticky_r[5];
    stat_view[`FP_STAT_EXC_HI:`FP_STAT_EXC_LO] = sticky_r[4:0];
  end

  always_comb begin
    rdata_nxt = 32'h00000000;
    if (acc_valid && !acc_write) begin
      case (sel)
        SEL_CONTROL:  rdata_nxt = ctrl_r;
        SEL_STATUS:   rdata_nxt = stat_view;
        SEL_FEATURE0: rdata_nxt = FEATURE0;
        default:      rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // single-cycle answer: each access is answered on the next edge
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r    <= ST_IDLE;
      resp_valid <= 1'b0;
      resp_undef <= 1'b0;
      resp_rdata <= 32'h00000000;
    end else begin
      resp_valid <= acc_valid;
      // unknown encoding, feature write or EL0 feature read is undefined
      resp_undef <= acc_valid && !hit;
      resp_rdata <= rdata_nxt;
      case (state_r)
        ST_IDLE:   state_r <= acc_valid ? ST_ANSWER : ST_IDLE;
        ST_ANSWER: state_r <= acc_valid ? ST_ANSWER : ST_IDLE;
        default:   state_r <= ST_IDLE;
      endcase
    end
  end

  // assertions
  property p_ctrl_write;
    @(posedge ref_clk) disable iff (!resetn)
      wr_ctrl |=> ctrl_r == ($past(acc_wdata) & 32'h07C00000);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write not masked");

  property p_mode_match;
    @(posedge ref_clk) disable iff (!resetn)
      ##1 (flush_zero_enable == ctrl_r[24] &&
           default_nan_enable == ctrl_r[25] &&
           alt_half_precision == ctrl_r[26] &&
           rounding_select == ctrl_r[23:22]);
  endproperty
  a_mode_match: assert property (p_mode_match)
    else $error("mode outputs differ from control register");

  property p_feature_read;
    @(posedge ref_clk) disable iff (!resetn)
      (acc_valid && !acc_write && sel == SEL_FEATURE0)
        |=> resp_rdata == 32'h10110222 && !resp_undef;
  endproperty
  a_feature_read: assert property (p_feature_read)
    else $error("feature read value wrong");

  property p_feature_el0;
    @(posedge ref_clk) disable iff (!resetn)
      (acc_valid && acc_el == 2'h0 && acc_op1 == 3'h0 && acc_crm == 4'h3)
        |=> resp_undef;
  endproperty
  a_feature_el0: assert property (p_feature_el0)
    else $error("feature register reachable from EL0");

  property p_sticky_hold;
    @(posedge ref_clk) disable iff (!resetn)
      (sticky_r[0] && !wr_stat) |=> sticky_r[0];
  endproperty
  a_sticky_hold: assert property (p_sticky_hold)
    else $error("invalid sticky cleared without write");

  property p_sticky_set;
    @(posedge ref_clk) disable iff (!resetn)
      ixc_event |=> sticky_r[4];
  endproperty
  a_sticky_set: assert property (p_sticky_set)
    else $error("inexact event lost");

  property p_sat_set;
    @(posedge ref_clk) disable iff (!resetn)
      sat_event ##1 !wr_stat ##1
        (acc_valid && !acc_write && sel == SEL_STATUS) |=> resp_rdata[27];
  endproperty
  a_sat_set: assert property (p_sat_set)
    else $error("saturation sticky not read back");

  property p_stat_reserved;
    @(posedge ref_clk) disable iff (!resetn)
      (acc_valid && !acc_write && sel == SEL_STATUS)
        |=> (resp_rdata & 32'h07FFFF60) == 32'h00000000;
  endproperty
  a_stat_reserved: assert property (p_stat_reserved)
    else $error("status reserved bits nonzero");

  property p_ctrl_read;
    @(posedge ref_clk) disable iff (!resetn)
      (acc_valid && !acc_write && sel == SEL_CONTROL)
        |=> resp_rdata == $past(ctrl_r) && resp_valid;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control read mismatch");

  property p_ahp_write;
    @(posedge ref_clk) disable iff (!resetn)
      wr_ctrl |=> alt_half_precision == $past(acc_wdata[`FP_CTRL_AHP_BIT]);
  endproperty
  a_ahp_write: assert property (p_ahp_write)
    else $error("half precision select not taken from write");

  property p_dn_write;
    @(posedge ref_clk) disable iff (!resetn)
      wr_ctrl |=> default_nan_enable == $past(acc_wdata[`FP_CTRL_DN_BIT]);
  endproperty
  a_dn_write: assert property (p_dn_write)
    else $error("default nan enable not taken from write");

  property p_fz_write;
    @(posedge ref_clk) disable iff (!resetn)
      wr_ctrl |=> flush_zero_enable == $past(acc_wdata[`FP_CTRL_FZ_BIT]);
  endproperty
  a_fz_write: assert property (p_fz_write)
    else $error("flush to zero enable not taken from write");

  property p_rnd_write;
    @(posedge ref_clk) disable iff (!resetn)
      wr_ctrl |=> rounding_select ==
        $past(acc_wdata[`FP_CTRL_RM_HI:`FP_CTRL_RM_LO]);
  endproperty
  a_rnd_write: assert property (p_rnd_write)
    else $error("rounding select not taken from write");

  property p_cmp_load;
    @(posedge ref_clk) disable iff (!resetn)
      cmp_flags_valid |=> cmp_r == $past(cmp_flags);
  endproperty
  a_cmp_load: assert property (p_cmp_load)
    else $error("comparison flags not loaded");

  property p_idc_set;
    @(posedge ref_clk) disable iff (!resetn)
      idc_event |=> sticky_r[5];
  endproperty
  a_idc_set: assert property (p_idc_set)
    else $error("input denormal event lost");

  property p_ufc_set;
    @(posedge ref_clk) disable iff (!resetn)
      ufc_event |=> sticky_r[3];
  endproperty
  a_ufc_set: assert property (p_ufc_set)
    else $error("underflow event lost");

  property p_ofc_set;
    @(posedge ref_clk) disable iff (!resetn)
      ofc_event |=> sticky_r[2];
  endproperty
  a_ofc_set: assert property (p_ofc_set)
    else $error("overflow event lost");

  property p_dzc_set;
    @(posedge ref_clk) disable iff (!resetn)
      dzc_event |=> sticky_r[1];
  endproperty
  a_dzc_set: assert property (p_dzc_set)
    else $error("divide by zero event lost");

  property p_sw_set;
    @(posedge ref_clk) disable iff (!resetn)
      (wr_stat && acc_wdata[`FP_STAT_EXC_LO]) |=> sticky_r[0];
  endproperty
  a_sw_set: assert property (p_sw_set)
    else $error("software one did not set sticky bit");

  property p_sw_clear;
    @(posedge ref_clk) disable iff (!resetn)
      (wr_stat && !acc_wdata[`FP_STAT_EXC_HI] && !ixc_event)
        |=> !sticky_r[4];
  endproperty
  a_sw_clear: assert property (p_sw_clear)
    else $error("software zero did not clear inexact sticky");

  property p_feature_write;
    @(posedge ref_clk) disable iff (!resetn)
      (acc_valid && acc_write && acc_op0 == 2'h3 && acc_op1 == 3'h0 &&
       acc_crn == 4'h0 && acc_crm == 4'h3 && acc_op2 == 3'h0)
        |=> resp_undef;
  endproperty
  a_feature_write: assert property (p_feature_write)
    else $error("feature register write accepted");

  property p_stat_read;
    @(posedge ref_clk) disable iff (!resetn)
      (acc_valid && !acc_write && sel == SEL_STATUS)
        |=> resp_rdata == $past(stat_view) && resp_valid;
  endproperty
  a_stat_read: assert property (p_stat_read)
    else $error("status read mismatch");
endmodule // fp_control_status_regs
`default_nettype wire

// [verilog/fp_sticky_bit.sv]
// one sticky flag: hardware and software set it, only software zero clears
`default_nettype none
module fp_sticky_bit (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic hw_set,
  input  wire logic sw_write,
  input  wire logic sw_value,
  output logic      flag_r
);
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flag_r <= 1'b0;
    end else if (hw_set) begin
      // a same-cycle event beats a software clear
      flag_r <= 1'b1;
    end else if (sw_write) begin
      flag_r <= sw_value;
    end
  end
endmodule // fp_sticky_bit
`default_nettype wire

// [verilog/fp_sysreg_decode.sv]
// decodes a system-register encoding and exception level into a selection
`default_nettype none
`include "fp_regs_cfg.svh"
module fp_sysreg_decode
  import fp_regs_pkg::*;
(
  input  wire logic [1:0] op0,
  input  wire logic [2:0] op1,
  input  wire logic [3:0] crn,
  input  wire logic [3:0] crm,
  input  wire logic [2:0] op2,
  input  wire logic [1:0] exc_level,
  input  wire logic       is_write,
  output logic            hit,
  output reg_sel_t        sel
);
  logic fp_space;
  logic id_space;

  assign fp_space = (op0 == `FP_ENC_OP0_SYS) && (op1 == `FP_ENC_OP1_USER) &&
                    (crn == `FP_ENC_CRN_FP) && (crm == `FP_ENC_CRM_FP);
  assign id_space = (op0 == `FP_ENC_OP0_SYS) && (op1 == `FP_ENC_OP1_ID) &&
                    (crn == `FP_ENC_CRN_ID) && (crm == `FP_ENC_CRM_ID);

  always_comb begin
    sel = SEL_NONE;
    if (fp_space && op2 == `FP_ENC_OP2_CTRL) begin
      sel = SEL_CONTROL;
    end else if (fp_space && op2 == `FP_ENC_OP2_STAT) begin
      sel = SEL_STATUS;
    end else if (id_space && op2 == `FP_ENC_OP2_FEAT0 && !is_write &&
                 exc_level != 2'h0) begin
      sel = SEL_FEATURE0;
    end
  end

  assign hit = (sel != SEL_NONE);
endmodule // fp_sysreg_decode
`default_nettype wire
